// ==== rtl/iolpm_port.sv ====
// io-link port controller: mode select, parameter storage decisions, device validation
//
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
`include "iolpm_map.svh"
// Summary of operation
// R01: digital input never starts communication by itself
// R02: freeze digital input during optional communication
// R03: digital output drives line, never communicates
// R04: inactive port switches sensor supply off
// R05: sio-param mode parameterizes once at startup
// R06: com mode starts communication and cyclic exchange
// R07: process data size 1 to 32 bytes
// R08: storage disabled: no transfer, keep stored set
// R09: download only with usable stored set
// R10: download on difference unless device locked
// R11: upload when master holds no valid set
// R12: storage command sets device upload request flag
// R13: both mode stores uploads and compares each connection
// R14: upload/download decision table
// R15: disabled-and-cleared erases stored set
// R16: device raises upload flag after block writes
// R17: no validation starts without id compare
// R18: compatible mode needs vendor and device id
// R19: identical mode also needs serial number
// R20: ids configured as high and low bytes
// R21: serial number at most 16 characters
// R22: mismatch blocks exchange and flags event
module iolpm_port
  import iolpm_pkg::*;
(
  input wire logic i_clock, // 40 mhz clock
  input wire logic i_reset, // synchronous reset, active high
  input wire logic [5:0] i_avs_address, // word address
  input wire logic i_avs_read, // read strobe
  input wire logic i_avs_write, // write strobe
  input wire logic [31:0] i_avs_writedata, // write data
  input wire logic [3:0] i_avs_byteenable, // byte enables
  output logic [31:0] o_avs_readdata, // read data
  output logic o_avs_waitrequest, // stall
  input wire logic i_cq_in, // c/q line level as sensed
  input wire logic i_dout_value, // output value in digital output mode
  input wire logic i_com_bits, // cyclic control bit, starts communication in digital input mode only
  input wire iolpm_devstat_t i_dev, // status reported by the link layer
  input wire logic i_param_done, // parameterization or transfer finished
  input wire logic i_dev_change, // new device connection, pulse
  output logic o_com_enable, // request link layer to communicate
  output logic o_pd_exchange, // cyclic process data allowed
  output logic o_cq_out, // c/q driven value
  output logic o_cq_oe, // c/q output enable
  output logic o_sensor_power, // l+ supply enable
  output logic o_di_state, // reported digital input
  output iolpm_dsreq_t o_ds_req, // storage transfer request
  output logic o_store_cmd, // send storage command to device, pulse
  output logic [5:0] o_pd_size, // configured process data bytes
  output logic o_ds_valid // master holds a valid stored set
);
  localparam int STARTUP_CYC = `IOLPM_STARTUP_CYC;
  iolpm_mode_t mode_reg;
  iolpm_store_t store_reg;
  iolpm_valid_t valid_reg;
  logic [5:0] pd_size_reg;
  iolpm_ident_t exp_id_reg;
  logic [31:0] dev_id_reg;
  logic [31:0] ser_exp_reg [`IOLPM_SER_WORDS];
  logic [31:0] ser_dev_reg [`IOLPM_SER_WORDS];
  logic ds_valid_reg;
  logic sio_done_reg;
  logic [15:0] start_cnt_reg;
  logic mismatch_reg;
  logic event_reg;
  logic wr_commit;
  logic [31:0] rdata_next;
  logic hit_ctrl;
  logic id_ok;
  logic ser_ok;
  logic accept;
  logic [1:0] ds_dec;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // R14 decision: bit1 upload, bit0 download
  function automatic logic [1:0] decide(input logic m_valid, input iolpm_devstat_t d);
    logic [1:0] r;
    r = 2'h0;
    if (!m_valid) begin
      r = (d.upload_flag || d.dev_valid) ? 2'h2 : 2'h0;
    end else if (d.upload_flag && d.dev_valid) begin
      r = 2'h2;
    end else if (!d.data_equal) begin
      r = 2'h1;
    end
    return r;
  endfunction

  // one wait state per access; a write lands only at the edge that sees waitrequest low
  assign accept = (i_avs_read || i_avs_write) && o_avs_waitrequest;
  assign wr_commit = i_avs_write && !o_avs_waitrequest;
  assign hit_ctrl = wr_commit && (i_avs_address == `IOLPM_ADDR_CTRL);

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= !accept;
    end
  end

  // configuration writes
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      mode_reg <= IOLPM_DI;
      store_reg <= IOLPM_DS_OFF;
      valid_reg <= IOLPM_VAL_NONE;
      pd_size_reg <= `IOLPM_PD_MIN;
      exp_id_reg <= '0;
      for (int i = 0; i < `IOLPM_SER_WORDS; i++) begin
        ser_exp_reg[i] <= '0;
      end
    end else if (wr_commit) begin
      unique case (i_avs_address)
        `IOLPM_ADDR_MODE: begin
          if (i_avs_byteenable[0] && i_avs_writedata[2:0] <= 3'h4) begin
            mode_reg <= iolpm_mode_t'(i_avs_writedata[2:0]);
          end
        end
        `IOLPM_ADDR_PDSIZE: begin
          // out-of-range sizes are clamped into 1..32
          if (i_avs_byteenable[0]) begin
            if (i_avs_writedata[7:0] == 8'h00) begin
              pd_size_reg <= `IOLPM_PD_MIN; // R07
            end else if (i_avs_writedata[7:0] > 8'h20) begin
              pd_size_reg <= `IOLPM_PD_MAX; // R07
            end else begin
              pd_size_reg <= i_avs_writedata[5:0]; // R07
            end
          end
        end
        `IOLPM_ADDR_STORE: begin
          if (i_avs_byteenable[0] && i_avs_writedata[2:0] <= 3'h4) begin
            store_reg <= iolpm_store_t'(i_avs_writedata[2:0]);
          end
        end
        `IOLPM_ADDR_VALID: begin
          if (i_avs_byteenable[0] && i_avs_writedata[1:0] != 2'h3) begin
            valid_reg <= iolpm_valid_t'(i_avs_writedata[1:0]);
          end
        end
        `IOLPM_ADDR_VENDOR: begin
          if (i_avs_byteenable[1]) begin
            exp_id_reg.expected_vendor_high_byte <= i_avs_writedata[15:8]; // R20
          end
          if (i_avs_byteenable[0]) begin
            exp_id_reg.expected_vendor_low_byte <= i_avs_writedata[7:0]; // R20
          end
        end
        `IOLPM_ADDR_PRODUCT: begin
          if (i_avs_byteenable[1]) begin
            exp_id_reg.expected_product_high_byte <= i_avs_writedata[15:8]; // R20
          end
          if (i_avs_byteenable[0]) begin
            exp_id_reg.expected_product_low_byte <= i_avs_writedata[7:0]; // R20
          end
        end
        default: begin
          // 4 words of 4 characters: 16 characters at most
          if (i_avs_address[5:2] == `IOLPM_ADDR_SER_EXP >> 2) begin
            ser_exp_reg[i_avs_address[1:0]] <=
              merge(ser_exp_reg[i_avs_address[1:0]], i_avs_writedata, i_avs_byteenable); // R21
          end
        end
      endcase
    end
  end

  // identity reported by the device, written by software over the Avalon-MM slave port
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      dev_id_reg <= '0;
      for (int i = 0; i < `IOLPM_SER_WORDS; i++) begin
        ser_dev_reg[i] <= '0;
      end
    end else if (wr_commit) begin
      if (i_avs_address == `IOLPM_ADDR_DEVID) begin
        dev_id_reg <= merge(dev_id_reg, i_avs_writedata, i_avs_byteenable);
      end else if (i_avs_address[5:2] == `IOLPM_ADDR_SER_DEV >> 2) begin
        ser_dev_reg[i_avs_address[1:0]] <=
          merge(ser_dev_reg[i_avs_address[1:0]], i_avs_writedata, i_avs_byteenable);
      end
    end
  end

  assign id_ok = (dev_id_reg == exp_id_reg); // R18
  always_comb begin
    ser_ok = 1'b1;
    for (int i = 0; i < `IOLPM_SER_WORDS; i++) begin
      if (ser_dev_reg[i] != ser_exp_reg[i]) begin
        ser_ok = 1'b0; // R19
      end
    end
  end

  // validation outcome; none skips the compare entirely
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      mismatch_reg <= 1'b0;
    end else begin
      unique case (valid_reg)
        IOLPM_VAL_NONE: mismatch_reg <= 1'b0; // R17
        IOLPM_VAL_COMPAT: mismatch_reg <= !id_ok; // R18
        IOLPM_VAL_IDENT: mismatch_reg <= !(id_ok && ser_ok); // R19
        default: mismatch_reg <= 1'b0;
      endcase
    end
  end

  // sticky mismatch event; a new mismatch wins over the clear
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      event_reg <= 1'b0;
    end else if (mismatch_reg && i_dev.link_up) begin
      event_reg <= 1'b1; // R22
    end else if (hit_ctrl && i_avs_byteenable[0] && i_avs_writedata[1]) begin
      event_reg <= 1'b0;
    end
  end

  // startup parameterization window for sio-param mode
  always_ff @(posedge i_clock) begin
    if (i_reset || mode_reg != IOLPM_SIOPAR) begin
      start_cnt_reg <= '0;
      sio_done_reg <= 1'b0;
    end else if (!sio_done_reg) begin
      if (i_param_done && start_cnt_reg >= 16'(STARTUP_CYC)) begin
        sio_done_reg <= 1'b1; // R05
      end else if (start_cnt_reg != 16'hffff) begin
        start_cnt_reg <= start_cnt_reg + 16'h0001;
      end
    end
  end

  // port line and power outputs
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_com_enable <= 1'b0;
      o_pd_exchange <= 1'b0;
      o_cq_out <= 1'b0;
      o_cq_oe <= 1'b0;
      o_sensor_power <= 1'b1;
    end else begin
      o_sensor_power <= (mode_reg != IOLPM_INACT); // R04
      o_cq_oe <= (mode_reg == IOLPM_DO); // R03
      o_cq_out <= (mode_reg == IOLPM_DO) && i_dout_value; // R03
      unique case (mode_reg)
        IOLPM_DI: o_com_enable <= i_com_bits; // R01
        IOLPM_SIOPAR: o_com_enable <= !sio_done_reg; // R05
        IOLPM_COM: o_com_enable <= 1'b1; // R06
        default: o_com_enable <= 1'b0; // R03
      endcase
      o_pd_exchange <= (mode_reg == IOLPM_COM) && i_dev.link_up && !mismatch_reg; // R06 R22
    end
  end

  // digital input reporting, frozen while a session runs
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_di_state <= 1'b0;
    end else if (!(o_com_enable && i_dev.link_up)) begin
      o_di_state <= i_cq_in; // R02
    end
  end

  assign ds_dec = decide(ds_valid_reg, i_dev); // R14

  // storage transfer requests on each new connection with the link up and no id mismatch
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_ds_req <= '0;
    end else if (i_dev_change && i_dev.link_up && !mismatch_reg) begin
      unique case (store_reg)
        IOLPM_DS_DOWN: begin
          o_ds_req.upload <= 1'b0;
          o_ds_req.download <= ds_valid_reg && !i_dev.data_equal && !i_dev.locked; // R09 R10
        end
        IOLPM_DS_UP: begin
          o_ds_req.upload <= ds_dec[1]; // R11
          o_ds_req.download <= 1'b0;
        end
        IOLPM_DS_BOTH: begin
          o_ds_req.upload <= ds_dec[1]; // R11 R13
          o_ds_req.download <= ds_dec[0] && !i_dev.locked; // R13
        end
        default: o_ds_req <= '0; // R08
      endcase
    end else if (i_param_done) begin
      o_ds_req <= '0;
    end
  end

  // stored-set validity: uploads fill it, clear option erases it
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      ds_valid_reg <= 1'b0;
    end else if (store_reg == IOLPM_DS_CLEAR) begin
      ds_valid_reg <= 1'b0; // R15
    end else if (o_ds_req.upload && i_param_done) begin
      ds_valid_reg <= 1'b1; // R13
    end
  end

  // software asks for the storage command, device then raises its upload flag
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_store_cmd <= 1'b0;
    end else begin
      o_store_cmd <= hit_ctrl && i_avs_byteenable[0] && i_avs_writedata[0]
                     && (store_reg == IOLPM_DS_UP || store_reg == IOLPM_DS_BOTH); // R12
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_pd_size <= `IOLPM_PD_MIN;
      o_ds_valid <= 1'b0;
    end else begin
      o_pd_size <= pd_size_reg;
      o_ds_valid <= ds_valid_reg;
    end
  end

  always_comb begin
    rdata_next = '0;
    unique case (i_avs_address)
      `IOLPM_ADDR_MODE: rdata_next = {29'h0, mode_reg};
      `IOLPM_ADDR_PDSIZE: rdata_next = {26'h0, pd_size_reg};
      `IOLPM_ADDR_STORE: rdata_next = {29'h0, store_reg};
      `IOLPM_ADDR_VALID: rdata_next = {30'h0, valid_reg};
      `IOLPM_ADDR_VENDOR: rdata_next = {16'h0, exp_id_reg[31:16]};
      `IOLPM_ADDR_PRODUCT: rdata_next = {16'h0, exp_id_reg[15:0]};
      `IOLPM_ADDR_DEVID: rdata_next = dev_id_reg;
      `IOLPM_ADDR_STATUS: rdata_next = {26'h0, o_pd_exchange, o_com_enable, ds_valid_reg,
                                         mismatch_reg, o_ds_req};
      `IOLPM_ADDR_EVENT: rdata_next = {31'h0, event_reg};
      default: begin
        if (i_avs_address[5:2] == `IOLPM_ADDR_SER_EXP >> 2) begin
          rdata_next = ser_exp_reg[i_avs_address[1:0]];
        end else if (i_avs_address[5:2] == `IOLPM_ADDR_SER_DEV >> 2) begin
          rdata_next = ser_dev_reg[i_avs_address[1:0]];
        end
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_avs_readdata <= '0;
    end else if (i_avs_read && accept) begin
      o_avs_readdata <= rdata_next;
    end
  end

  inactive_power_a: assert property (@(posedge i_clock) disable iff (i_reset) // R04
    mode_reg == IOLPM_INACT |=> !o_sensor_power)
    else $error("sensor power on while port inactive");
  dout_no_com_a: assert property (@(posedge i_clock) disable iff (i_reset) // R03
    mode_reg == IOLPM_DO |=> !o_com_enable && o_cq_oe)
    else $error("digital output mode communicates");
  di_freeze_a: assert property (@(posedge i_clock) disable iff (i_reset) // R02
    o_com_enable && i_dev.link_up |=> $stable(o_di_state))
    else $error("input state changed during session");
  store_off_a: assert property (@(posedge i_clock) disable iff (i_reset) // R08
    store_reg == IOLPM_DS_OFF && i_dev_change |=> o_ds_req == 2'h0)
    else $error("transfer while storage disabled");
  clear_erase_a: assert property (@(posedge i_clock) disable iff (i_reset) // R15
    store_reg == IOLPM_DS_CLEAR |=> !ds_valid_reg ##1 !o_ds_valid)
    else $error("stored set survives clear");
  locked_dl_a: assert property (@(posedge i_clock) disable iff (i_reset) // R10
    i_dev_change && i_dev.locked |=> !o_ds_req.download)
    else $error("download to locked device");
  mismatch_pd_a: assert property (@(posedge i_clock) disable iff (i_reset) // R22
    mismatch_reg |=> !o_pd_exchange)
    else $error("process data despite mismatch");
  noval_ok_a: assert property (@(posedge i_clock) disable iff (i_reset) // R17
    valid_reg == IOLPM_VAL_NONE |=> !mismatch_reg)
    else $error("mismatch with validation off");
  pd_range_a: assert property (@(posedge i_clock) disable iff (i_reset) // R07
    o_pd_size >= 6'h01 && o_pd_size <= 6'h20)
    else $error("process data size out of range");
endmodule

// ==== pkg/iolpm_map.svh ====
// register offsets, command codes, reset values and timing counts of the port controller
`ifndef IOLPM_MAP_SVH
`define IOLPM_MAP_SVH
`define IOLPM_ADDR_MODE 6'h00
`define IOLPM_ADDR_PDSIZE 6'h01
`define IOLPM_ADDR_STORE 6'h02
`define IOLPM_ADDR_VALID 6'h03
`define IOLPM_ADDR_VENDOR 6'h04
`define IOLPM_ADDR_PRODUCT 6'h05
`define IOLPM_ADDR_DEVID 6'h06
`define IOLPM_ADDR_DEVFLAGS 6'h07
`define IOLPM_ADDR_CTRL 6'h08
`define IOLPM_ADDR_STATUS 6'h09
`define IOLPM_ADDR_EVENT 6'h0a
`define IOLPM_ADDR_SER_EXP 6'h10
`define IOLPM_ADDR_SER_DEV 6'h14
`define IOLPM_SER_WORDS 4
`define IOLPM_PD_MIN 6'h01
`define IOLPM_PD_MAX 6'h20
`define IOLPM_CMD_INDEX 16'h0002
`define IOLPM_CMD_SUBINDEX 8'h00
`define IOLPM_CMD_VALUE 8'h05
`define IOLPM_STARTUP_NS 1000
`define IOLPM_CLK_NS 25
`define IOLPM_STARTUP_CYC ((`IOLPM_STARTUP_NS + `IOLPM_CLK_NS - 1) / `IOLPM_CLK_NS)
`endif

// ==== pkg/iolpm_pkg.sv ====
// types of the io-link port mode, storage and validation controller
package iolpm_pkg;
  typedef enum logic [2:0] {
    IOLPM_DI = 3'h0,
    IOLPM_DO = 3'h1,
    IOLPM_INACT = 3'h2,
    IOLPM_SIOPAR = 3'h3,
    IOLPM_COM = 3'h4
  } iolpm_mode_t;
  typedef enum logic [2:0] {
    IOLPM_DS_OFF = 3'h0,
    IOLPM_DS_DOWN = 3'h1,
    IOLPM_DS_UP = 3'h2,
    IOLPM_DS_BOTH = 3'h3,
    IOLPM_DS_CLEAR = 3'h4
  } iolpm_store_t;
  typedef enum logic [1:0] {
    IOLPM_VAL_NONE = 2'h0,
    IOLPM_VAL_COMPAT = 2'h1,
    IOLPM_VAL_IDENT = 2'h2
  } iolpm_valid_t;
  typedef struct packed {
    logic [7:0] expected_vendor_high_byte;
    logic [7:0] expected_vendor_low_byte;
    logic [7:0] expected_product_high_byte;
    logic [7:0] expected_product_low_byte;
  } iolpm_ident_t;
  typedef struct packed {
    logic link_up;
    logic upload_flag;
    logic dev_valid;
    logic locked;
    logic data_equal;
  } iolpm_devstat_t;
  typedef struct packed {
    logic upload;
    logic download;
  } iolpm_dsreq_t;
endpackage

// ==== verif/iolpm_dev_model.sv ====
// behavioural io-link field device on the far side of the port
`timescale 1ns/10ps
module iolpm_dev_model
  import iolpm_pkg::*;
(
  input wire logic i_clock, // clock
  input wire logic i_reset, // sync reset, active high
  input wire logic i_connect, // plug a device in, pulse
  input wire logic i_block_wr, // parameters written in block mode, pulse
  input wire logic i_startup_done, // startup parameterization finished, pulse
  input wire logic [2:0] i_flags, // {dev_valid,locked,data_equal}
  input wire logic i_sw_level, // switching output of the device
  input wire logic i_com_enable, // master asks for communication
  input wire logic i_cq_out, // master drive value
  input wire logic i_cq_oe, // master drive enable
  input wire logic i_store_cmd, // storage command from master
  input wire iolpm_dsreq_t i_ds_req, // transfer requested by master
  output iolpm_devstat_t o_dev, // status toward master
  output logic o_param_done, // transfer finished, pulse
  output logic o_dev_change, // new connection, pulse
  output logic o_cq_in // wire level
);
  logic [3:0] busy_reg;
  logic link_reg;
  logic upflag_reg;
  // the device drives its switching output whenever the master lets go
  assign o_cq_in = i_cq_oe ? i_cq_out : i_sw_level;
  assign o_dev = {link_reg, upflag_reg, i_flags};
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      link_reg <= 1'b0;
      upflag_reg <= 1'b0;
      busy_reg <= 4'h0;
      o_param_done <= 1'b0;
      o_dev_change <= 1'b0;
    end else begin
      link_reg <= i_com_enable;
      o_dev_change <= i_connect;
      o_param_done <= (busy_reg == 4'h1) || i_startup_done;
      // a transfer is never instant, so the master must wait for done
      if (busy_reg != 4'h0) begin
        busy_reg <= busy_reg - 4'h1;
      end else if (i_ds_req != 2'b00 && !o_param_done) begin
        busy_reg <= 4'h6;
      end
      if (i_store_cmd || i_block_wr) begin
        upflag_reg <= 1'b1;
      end else if (o_param_done && i_ds_req.upload) begin
        upflag_reg <= 1'b0;
      end
    end
  end
endmodule

// ==== verif/tb_iolpm_port.sv ====
// self-checking bench of the io-link port controller
`timescale 1ns/10ps
`include "iolpm_map.svh"
module tb_iolpm_port
  import iolpm_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] avs_adr = 6'h00;
  logic avs_rd = 1'b0;
  logic avs_wr = 1'b0;
  logic [31:0] avs_wd = 32'h0;
  logic [31:0] avs_rdata;
  logic avs_wait;
  logic dout = 1'b1;
  logic comb = 1'b0;
  logic conn = 1'b0;
  logic blk = 1'b0;
  logic sdone = 1'b0;
  logic sw = 1'b0;
  logic [2:0] flags = 3'h0;
  logic cq_in, pdone, dchg, com_en, pdx, cq_out, cq_oe, pwr, di, scmd, dsv;
  logic [5:0] pdsz;
  iolpm_devstat_t dev;
  iolpm_dsreq_t ds_req;
  int failures = 0;
  int n_compared = 0;
  iolpm_port i_iolpm_port (.i_clock(clk), .i_reset(rst), .i_avs_address(avs_adr),
    .i_avs_read(avs_rd), .i_avs_write(avs_wr), .i_avs_writedata(avs_wd),
    .i_avs_byteenable(4'hf), .o_avs_readdata(avs_rdata), .o_avs_waitrequest(avs_wait),
    .i_cq_in(cq_in), .i_dout_value(dout), .i_com_bits(comb), .i_dev(dev),
    .i_param_done(pdone), .i_dev_change(dchg), .o_com_enable(com_en), .o_pd_exchange(pdx),
    .o_cq_out(cq_out), .o_cq_oe(cq_oe), .o_sensor_power(pwr), .o_di_state(di),
    .o_ds_req(ds_req), .o_store_cmd(scmd), .o_pd_size(pdsz), .o_ds_valid(dsv));
  iolpm_dev_model i_iolpm_dev_model (.i_clock(clk), .i_reset(rst), .i_connect(conn),
    .i_block_wr(blk), .i_flags(flags), .i_sw_level(sw), .i_com_enable(com_en),
    .i_startup_done(sdone),
    .i_cq_out(cq_out), .i_cq_oe(cq_oe), .i_store_cmd(scmd), .i_ds_req(ds_req),
    .o_dev(dev), .o_param_done(pdone), .o_dev_change(dchg), .o_cq_in(cq_in));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic test_done();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 60) begin
      failures++;
      test_done();
    end
  endtask
  // one avalon access; waits for waitrequest low, never assumes a latency
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge clk);
    avs_adr <= a;
    avs_wd <= d;
    avs_wr <= w;
    avs_rd <= !w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_wait !== 1'b0 && n < 60);
    q = avs_rdata;
    tmo(n);
    avs_wr <= 1'b0;
    avs_rd <= 1'b0;
  endtask
  task automatic bw(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic br(input string nm, input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, q, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // connect a device with the given flags and check the transfer request
  task automatic plug(input logic [2:0] f, input logic [1:0] e);
    int n;
    @(posedge clk);
    flags <= f;
    conn <= 1'b1;
    @(posedge clk);
    conn <= 1'b0;
    tick(4);
    chk("ds_req", 32'(ds_req), 32'(e));
    n = 0;
    while (ds_req !== 2'b00 && n < 60) begin
      @(posedge clk);
      n++;
    end
    tmo(n);
    tick(2);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    br("mode", `IOLPM_ADDR_MODE, 32'h0);
    br("pdsize", `IOLPM_ADDR_PDSIZE, 32'h1);
    br("store", `IOLPM_ADDR_STORE, 32'h0);
    br("valid", `IOLPM_ADDR_VALID, 32'h0);
    chk("ds_valid", 32'(dsv), 32'h0);
    comb <= 1'b1;
    for (int m = 0; m < 5; m++) begin
      bw(`IOLPM_ADDR_MODE, 32'(m));
      tick(2);
      chk("sensor_power", 32'(pwr), 32'(m != 2));
      if (m != 3) chk("com_enable", 32'(com_en), 32'(m == 0 || m == 4));
      if (m < 3) chk("cq_oe", 32'(cq_oe), 32'(m == 1));
      if (m == 1) chk("cq_out", 32'(cq_out), 32'h1);
    end
    bw(`IOLPM_ADDR_MODE, 32'h7);
    br("mode", `IOLPM_ADDR_MODE, 32'h4);
    br("unmapped", 6'h07, 32'h0);
    bw(`IOLPM_ADDR_MODE, 32'h0);
    @(posedge clk);
    comb <= 1'b0;
    sw <= 1'b1;
    tick(3);
    chk("di_state", 32'(di), 32'h1);
    @(posedge clk);
    comb <= 1'b1;
    tick(3);
    @(posedge clk);
    sw <= 1'b0;
    tick(3);
    chk("di_state", 32'(di), 32'h1);
    @(posedge clk);
    comb <= 1'b0;
    tick(3);
    chk("di_state", 32'(di), 32'h0);
    bw(`IOLPM_ADDR_MODE, 32'h3);
    tick(4);
    chk("com_enable", 32'(com_en), 32'h1);
    tick(40);
    @(posedge clk);
    sdone <= 1'b1;
    @(posedge clk);
    sdone <= 1'b0;
    tick(3);
    chk("com_enable", 32'(com_en), 32'h0);
    for (int k = 0; k < 64; k += 9) begin
      bw(`IOLPM_ADDR_PDSIZE, 32'(k));
      tick(2);
      chk("pd_size", 32'(pdsz), k == 0 ? 32'(`IOLPM_PD_MIN) :
          k > 32 ? 32'(`IOLPM_PD_MAX) : 32'(k));
    end
    bw(`IOLPM_ADDR_MODE, 32'h4);
    bw(`IOLPM_ADDR_STORE, 32'h1);
    plug(3'b100, 2'b00);
    bw(`IOLPM_ADDR_STORE, 32'h2);
    plug(3'b100, 2'b10);
    chk("ds_valid", 32'(dsv), 32'h1);
    bw(`IOLPM_ADDR_STORE, 32'h1);
    plug(3'b100, 2'b01);
    plug(3'b110, 2'b00);
    plug(3'b101, 2'b00);
    bw(`IOLPM_ADDR_STORE, 32'h0);
    plug(3'b100, 2'b00);
    chk("ds_valid", 32'(dsv), 32'h1);
    bw(`IOLPM_ADDR_STORE, 32'h3);
    plug(3'b100, 2'b01);
    bw(`IOLPM_ADDR_CTRL, 32'h1);
    #1;
    chk("store_cmd", 32'(scmd), 32'h1);
    plug(3'b101, 2'b10);
    @(posedge clk);
    blk <= 1'b1;
    @(posedge clk);
    blk <= 1'b0;
    plug(3'b101, 2'b10);
    bw(`IOLPM_ADDR_STORE, 32'h4);
    tick(2);
    chk("ds_valid", 32'(dsv), 32'h0);
    bw(`IOLPM_ADDR_STORE, 32'h2);
    plug(3'b100, 2'b10);
    bw(`IOLPM_ADDR_VENDOR, 32'h1234);
    bw(`IOLPM_ADDR_PRODUCT, 32'h5678);
    bw(`IOLPM_ADDR_DEVID, 32'h1234_5679);
    tick(3);
    chk("pd_exchange", 32'(pdx), 32'h1);
    bw(`IOLPM_ADDR_VALID, 32'h1);
    tick(3);
    chk("pd_exchange", 32'(pdx), 32'h0);
    br("event", `IOLPM_ADDR_EVENT, 32'h1);
    bw(`IOLPM_ADDR_DEVID, 32'h1234_5678);
    bw(`IOLPM_ADDR_CTRL, 32'h2);
    tick(3);
    chk("pd_exchange", 32'(pdx), 32'h1);
    br("event", `IOLPM_ADDR_EVENT, 32'h0);
    for (int i = 0; i < `IOLPM_SER_WORDS; i++) begin
      bw(`IOLPM_ADDR_SER_EXP + 6'(i), 32'h3031_3233 + 32'(i));
      bw(`IOLPM_ADDR_SER_DEV + 6'(i), 32'h3031_3233 + 32'(i == 3 ? 9 : i));
    end
    bw(`IOLPM_ADDR_VALID, 32'h2);
    tick(3);
    chk("pd_exchange", 32'(pdx), 32'h0);
    bw(`IOLPM_ADDR_SER_DEV + 6'h3, 32'h3031_3236);
    tick(3);
    chk("pd_exchange", 32'(pdx), 32'h1);
    test_done();
  end
endmodule
